// *** include/sid_pkg.sv ***
// shared constants and types for the subsystem_ident_doubleword loader
package sid_pkg;
	// configuration space offsets, byte addresses as printed
	localparam logic [7:0] SID_OFS_SUBSYS = 8'h40;
	localparam logic [7:0] SID_OFS_SYSCTL = 8'h80;
	localparam logic [7:0] SID_OFS_GSTAT = 8'h85;
	localparam logic [2:0] SID_MAX_FUNC = 3'h1;

	// system control fields and reset value
	localparam int SID_SYSCTL_WP_BIT = 5;
	localparam logic [31:0] SID_SYSCTL_RST = 32'h0000_0020;
	localparam logic [31:0] SID_SUBSYS_RST = 32'h0000_0000;

	// general status fields
	localparam int SID_GSTAT_PRESENT_BIT = 0;
	localparam int SID_GSTAT_ERROR_BIT = 1;
	localparam int SID_GSTAT_BUSY_BIT = 2;

	// two-wire addressing
	localparam logic [6:0] SID_SLAVE_ADDR = 7'h50;
	localparam logic [7:0] SID_WORD_ADDR = 8'h00;
	localparam logic [1:0] SID_LAST_BYTE = 2'h3;
	localparam logic [2:0] SID_LAST_BIT = 3'h7;

	// timing: one serial clock quarter-period on the link clock
	localparam int SID_LINK_PERIOD_NS = 125;
	localparam int SID_SCL_QTR_NS = 625;
	localparam int SID_SCL_QTR_CYC =
		(SID_SCL_QTR_NS + SID_LINK_PERIOD_NS - 1) / SID_LINK_PERIOD_NS;
	localparam logic [1:0] SID_SETTLE_CYC = 2'h3;

	// serial sequencer states, gray along the usual path except SID_ST_RSTART to SID_ST_WBIT, SID_ST_WACK to SID_ST_RBIT and SID_ST_DONE to SID_ST_IDLE
	typedef enum logic [3:0] {
		SID_ST_IDLE = 4'h0,
		SID_ST_START = 4'h1,
		SID_ST_WBIT = 4'h3,
		SID_ST_WACK = 4'h2,
		SID_ST_RSTART = 4'h6,
		SID_ST_RBIT = 4'h7,
		SID_ST_RACK = 4'h5,
		SID_ST_STOP = 4'h4,
		SID_ST_DONE = 4'hc
	} sid_state_t;
endpackage

// *** design/sid_sync.sv ***
// two-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module sid_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sid_sync_t;

	sid_sync_t st_r;
	sid_sync_t st_nxt;

	// first stage feeds only the second stage
	always_comb begin
		st_nxt.meta = async_in;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stable;
endmodule

// *** design/sid_link.sv ***
// two-wire master that reads the four identification bytes, on the link clock
`timescale 1ns/1ps
module sid_link
	import sid_pkg::*;
#(
	parameter int QTR_CYC = SID_SCL_QTR_CYC
) (
	input wire logic link_clock,
	input wire logic reset,
	input wire logic req_tgl,
	input wire logic sda_in,
	output logic done_tgl,
	output logic [31:0] load_data,
	output logic load_err,
	output logic sda_oe,
	output logic scl_oe
);
	typedef struct packed {
		sid_state_t state;
		logic [7:0] div;
		logic [1:0] q;
		logic [2:0] bitn;
		logic [1:0] byten;
		logic rstarted;
		logic [7:0] shift;
		logic [31:0] data;
		logic err;
		logic done_tgl;
		logic req_seen;
		logic sda_low;
		logic scl_low;
	} sid_link_t;

	sid_link_t st_r;
	sid_link_t st_nxt;
	logic [1:0] in_s;
	logic req_s;
	logic sda_s;
	logic qtr_end;
	logic bit_end;

	sid_sync #(.WIDTH(2)) u_sync (
		.clock(link_clock),
		.reset(reset),
		.async_in({req_tgl, sda_in}),
		.sync_out(in_s)
	);
	assign req_s = in_s[1];
	assign sda_s = in_s[0];
	assign qtr_end = (st_r.div == 8'(QTR_CYC - 1));
	assign bit_end = qtr_end && (st_r.q == 2'h3);

	always_comb begin
		st_nxt = st_r;
		st_nxt.div = qtr_end ? 8'h00 : st_r.div + 8'h01;
		if (qtr_end) begin
			st_nxt.q = st_r.q + 2'h1;
		end
		// serial clock is low for the first half of every bit cell except the start cell after idle
		st_nxt.scl_low = (st_nxt.q < 2'h2);
		st_nxt.sda_low = 1'b0;
		unique case (st_r.state)
			SID_ST_IDLE: begin
				st_nxt.div = 8'h00;
				st_nxt.q = 2'h0;
				st_nxt.scl_low = 1'b0;
				if (req_s != st_r.req_seen) begin
					st_nxt.req_seen = req_s;
					st_nxt.state = SID_ST_START;
					st_nxt.shift = {SID_SLAVE_ADDR, 1'b0};
					st_nxt.bitn = 3'h0;
					st_nxt.byten = 2'h0;
					st_nxt.rstarted = 1'b0;
					st_nxt.err = 1'b0;
				end
			end
			SID_ST_START, SID_ST_RSTART: begin
				// data falls in the last quarter while the clock is high, and is held
				// low into the next cell so that it never moves together with the clock
				st_nxt.sda_low = (st_nxt.q == 2'h3) || bit_end;
				if (st_r.state == SID_ST_START) begin
					// coming from idle the clock stays released up to the first bit
					st_nxt.scl_low = bit_end;
				end
				if (bit_end) begin
					st_nxt.state = SID_ST_WBIT;
				end
			end
			SID_ST_WBIT: begin
				st_nxt.sda_low = ~st_r.shift[7];
				if (bit_end) begin
					st_nxt.shift = {st_r.shift[6:0], 1'b0};
					st_nxt.bitn = st_r.bitn + 3'h1;
					if (st_r.bitn == SID_LAST_BIT) begin
						st_nxt.state = SID_ST_WACK;
					end
				end
			end
			SID_ST_WACK: begin
				// released data line, slave pulls it low
				if (qtr_end && st_r.q == 2'h2 && sda_s) begin
					st_nxt.err = 1'b1;
				end
				if (bit_end) begin
					if (st_r.err) begin
						st_nxt.state = SID_ST_STOP;
					end else if (st_r.rstarted) begin
						st_nxt.state = SID_ST_RBIT;
						st_nxt.byten = 2'h0;
					end else if (st_r.byten == 2'h0) begin
						st_nxt.state = SID_ST_WBIT;
						st_nxt.shift = SID_WORD_ADDR;
						st_nxt.byten = 2'h1;
					end else begin
						st_nxt.state = SID_ST_RSTART;
						st_nxt.shift = {SID_SLAVE_ADDR, 1'b1};
						st_nxt.rstarted = 1'b1;
					end
				end
			end
			SID_ST_RBIT: begin
				if (qtr_end && st_r.q == 2'h2) begin
					st_nxt.shift = {st_r.shift[6:0], sda_s};
				end
				if (bit_end) begin
					st_nxt.bitn = st_r.bitn + 3'h1;
					if (st_r.bitn == SID_LAST_BIT) begin
						st_nxt.state = SID_ST_RACK;
					end
				end
			end
			SID_ST_RACK: begin
				// acknowledge all but the last byte
				st_nxt.sda_low = (st_r.byten != SID_LAST_BYTE);
				if (bit_end) begin
					// first byte lands in the top of the word
					st_nxt.data = {st_r.data[23:0], st_r.shift};
					st_nxt.byten = st_r.byten + 2'h1;
					st_nxt.state = (st_r.byten == SID_LAST_BYTE) ? SID_ST_STOP : SID_ST_RBIT;
				end
			end
			SID_ST_STOP: begin
				// data rises while the clock is high
				st_nxt.sda_low = (st_nxt.q != 2'h3);
				if (bit_end) begin
					// both lines stay released once the stop is on the wire
					st_nxt.sda_low = 1'b0;
					st_nxt.scl_low = 1'b0;
					st_nxt.state = SID_ST_DONE;
				end
			end
			SID_ST_DONE: begin
				st_nxt.scl_low = 1'b0;
				st_nxt.done_tgl = ~st_r.done_tgl;
				st_nxt.state = SID_ST_IDLE;
			end
			default: begin
				st_nxt.state = SID_ST_IDLE;
				st_nxt.scl_low = 1'b0;
			end
		endcase
	end

	always_ff @(posedge link_clock or posedge reset) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign done_tgl = st_r.done_tgl;
	assign load_data = st_r.data;
	assign load_err = st_r.err;
	assign sda_oe = st_r.sda_low;
	assign scl_oe = st_r.scl_low;
endmodule

// *** design/sid_loader.sv ***
// subsystem identification register with serial eeprom loader
`timescale 1ns/1ps
module sid_loader
	import sid_pkg::*;
#(
	parameter int QTR_CYC = SID_SCL_QTR_CYC
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic link_clock,
	input wire logic primary_bus_reset,
	input wire logic global_reset,
	input wire logic low_power_hold,
	input wire logic power_switch_strobe_pin,
	input wire logic [2:0] cfg_func,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	input wire logic irq_mux_pin_6_i,
	output logic irq_mux_pin_6_o,
	output logic irq_mux_pin_6_oe,
	input wire logic irq_mux_pin_7_i,
	output logic irq_mux_pin_7_o,
	output logic irq_mux_pin_7_oe
);
	typedef struct packed {
		logic [31:0] sysctl;
		logic [31:0] subsys;
		logic present;
		logic data_err;
		logic busy;
		logic req_tgl;
		logic done_seen;
		logic load_pend;
		logic [1:0] settle;
		logic [31:0] rdata;
	} sid_core_t;

	sid_core_t st_r;
	sid_core_t st_nxt;
	logic [4:0] pins_s;
	logic primary_bus_reset_s;
	logic grst_s;
	logic hold_s;
	logic strap_s;
	logic done_s;
	logic link_done;
	logic [31:0] link_data;
	logic link_err;
	logic core_rst;
	logic settled;

	// true when the access targets the given offset in function 0 or 1
	function automatic logic sid_hit(input logic [2:0] func, input logic [7:0] addr,
		input logic [7:0] ofs);
		sid_hit = (func <= SID_MAX_FUNC) && (addr == ofs);
	endfunction

	sid_sync #(.WIDTH(5)) u_sync (
		.clock(clock),
		.reset(reset),
		.async_in({primary_bus_reset, global_reset, low_power_hold,
			power_switch_strobe_pin, link_done}),
		.sync_out(pins_s)
	);
	assign primary_bus_reset_s = pins_s[4];
	assign grst_s = pins_s[3];
	assign hold_s = pins_s[2];
	assign strap_s = pins_s[1];
	assign done_s = pins_s[0];

	// the data line lives on mux pin 6, the clock on mux pin 7
	sid_link #(.QTR_CYC(QTR_CYC)) u_link (
		.link_clock(link_clock),
		.reset(reset),
		.req_tgl(st_r.req_tgl),
		.sda_in(irq_mux_pin_6_i),
		.done_tgl(link_done),
		.load_data(link_data),
		.load_err(link_err),
		.sda_oe(irq_mux_pin_6_oe),
		.scl_oe(irq_mux_pin_7_oe)
	);

	// open-drain: only ever pulls low, pullups give the high level
	assign irq_mux_pin_6_o = 1'b0;
	assign irq_mux_pin_7_o = 1'b0;

	// suspend keeps bus resets away from the core and the loader
	assign core_rst = (primary_bus_reset_s | grst_s) & ~hold_s;
	// synchronised levels are not trusted until the pipeline has filled
	assign settled = (st_r.settle == SID_SETTLE_CYC);

	always_comb begin
		st_nxt = st_r;
		if (!settled) begin
			st_nxt.settle = st_r.settle + 2'h1;
		end
		// the link word is stable once its done toggle has crossed over
		if (done_s != st_r.done_seen) begin
			st_nxt.done_seen = done_s;
			if (st_r.busy) begin
				st_nxt.busy = 1'b0;
				st_nxt.data_err = link_err;
				if (!link_err) begin
					st_nxt.subsys = link_data;
				end
			end
		end
		if (settled && core_rst) begin
			st_nxt.sysctl = SID_SYSCTL_RST;
			st_nxt.subsys = SID_SUBSYS_RST;
			st_nxt.busy = 1'b0;
			st_nxt.data_err = 1'b0;
			st_nxt.load_pend = 1'b1;
		end else if (settled && st_r.load_pend) begin
			// strap pin low means an eeprom pulldown is fitted
			st_nxt.load_pend = 1'b0;
			st_nxt.present = ~strap_s;
			if (!strap_s) begin
				st_nxt.busy = 1'b1;
				st_nxt.data_err = 1'b0;
				st_nxt.req_tgl = ~st_r.req_tgl;
			end
		end else if (cfg_wr) begin
			if (sid_hit(cfg_func, cfg_addr, SID_OFS_SYSCTL)) begin
				st_nxt.sysctl = cfg_wdata;
			end
			// protect bit set makes the id read-only
			if (sid_hit(cfg_func, cfg_addr, SID_OFS_SUBSYS) &&
				!st_r.sysctl[SID_SYSCTL_WP_BIT]) begin
				st_nxt.subsys = cfg_wdata;
			end
		end
		st_nxt.rdata = 32'h0000_0000;
		if (sid_hit(cfg_func, cfg_addr, SID_OFS_SUBSYS)) begin
			st_nxt.rdata = st_r.subsys;
		end else if (sid_hit(cfg_func, cfg_addr, SID_OFS_SYSCTL)) begin
			st_nxt.rdata = st_r.sysctl;
		end else if (sid_hit(cfg_func, cfg_addr, SID_OFS_GSTAT)) begin
			st_nxt.rdata[SID_GSTAT_PRESENT_BIT] = st_r.present;
			st_nxt.rdata[SID_GSTAT_ERROR_BIT] = st_r.data_err;
			st_nxt.rdata[SID_GSTAT_BUSY_BIT] = st_r.busy;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st_r.sysctl <= SID_SYSCTL_RST;
			st_r.subsys <= SID_SUBSYS_RST;
			st_r.present <= 1'b0;
			st_r.data_err <= 1'b0;
			st_r.busy <= 1'b0;
			st_r.req_tgl <= 1'b0;
			st_r.done_seen <= 1'b0;
			st_r.load_pend <= 1'b1;
			st_r.settle <= 2'h0;
			st_r.rdata <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cfg_rdata = st_r.rdata;
endmodule

// *** testbench/sid_loader_props.sv ***
// port checker for the subsystem_ident_doubleword loader
`timescale 1ns/1ps
module sid_loader_props #(
	parameter int QTR_CYC = 2
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic link_clock,
	input wire logic power_switch_strobe_pin,
	input wire logic [2:0] cfg_func,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic irq_mux_pin_6_o,
	input wire logic irq_mux_pin_6_oe,
	input wire logic irq_mux_pin_7_o,
	input wire logic irq_mux_pin_7_oe
);
	logic [15:0] run_r;
	logic scl_r;
	// cycles spent in the present serial clock phase
	always_ff @(posedge link_clock or posedge reset) begin
		if (reset) begin
			run_r <= 16'h00ff;
			scl_r <= 1'b0;
		end else begin
			run_r <= (irq_mux_pin_7_oe != scl_r) ? 16'h0001 : run_r + 16'h0001;
			scl_r <= irq_mux_pin_7_oe;
		end
	end
	a_open_drain: assert property (@(posedge link_clock) disable iff (reset)
		!irq_mux_pin_6_o && !irq_mux_pin_7_o) else $error("pin driven high");
	a_reset_release: assert property (@(posedge link_clock) disable iff (reset)
		$fell(reset) |-> !irq_mux_pin_6_oe && !irq_mux_pin_7_oe) else $error("line driven");
	a_no_strap_idle: assert property (@(posedge link_clock) disable iff (reset)
		power_switch_strobe_pin [*8] |-> !irq_mux_pin_7_oe) else $error("clock without strap");
	a_scl_low_len: assert property (@(posedge link_clock) disable iff (reset)
		$fell(irq_mux_pin_7_oe) |-> run_r == 2 * QTR_CYC) else $error("clock low length");
	a_scl_high_len: assert property (@(posedge link_clock) disable iff (reset)
		$rose(irq_mux_pin_7_oe) |-> run_r >= 2 * QTR_CYC) else $error("clock high length");
	a_stop_idle: assert property (@(posedge link_clock) disable iff (reset)
		$fell(irq_mux_pin_6_oe) && !irq_mux_pin_7_oe |=> !irq_mux_pin_7_oe [*8])
		else $error("clock after stop");
	a_unmapped_zero: assert property (@(posedge clock) disable iff (reset)
		cfg_func > 3'h1 |=> cfg_rdata == 32'h0) else $error("unmapped read");
	a_sysctl_store: assert property (@(posedge clock) disable iff (reset)
		cfg_wr && cfg_addr == 8'h80 && cfg_func < 3'h2 ##1 cfg_addr == 8'h80
		|=> cfg_rdata == $past(cfg_wdata, 2)) else $error("control write lost");
	c_load: cover property (@(posedge link_clock) disable iff (reset) $rose(irq_mux_pin_7_oe));
	c_id_wr: cover property (@(posedge clock) disable iff (reset) cfg_wr && cfg_addr == 8'h40);
	c_ctl_wr: cover property (@(posedge clock) disable iff (reset) cfg_wr && cfg_addr == 8'h80);
endmodule
bind sid_loader sid_loader_props #(.QTR_CYC(QTR_CYC)) sid_loader_props_inst (.*);

// *** testbench/sid_eeprom_model.sv ***
// behavioural two-wire eeprom holding four id bytes
`timescale 1ns/1ps
module sid_eeprom_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	input wire logic [31:0] rom,
	output logic pull
);
	int cnt = 0;
	int ptr = 0;
	logic [7:0] sh;
	logic first = 1'b0;
	logic rd = 1'b0;
	logic ok = 1'b0;
	initial pull = 1'b0;
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			cnt = 0;
			first = 1'b1;
			rd = 1'b0;
		end
	end
	always @(posedge scl) begin
		if (cnt < 8)
			sh = {sh[6:0], sda};
		else if (rd && sda)
			ok = 1'b0;
		cnt = cnt + 1;
	end
	// drive only while the clock is low so data never moves under a high clock
	always @(negedge scl) begin
		pull = 1'b0;
		if (cnt == 9)
			cnt = 0;
		if (cnt == 8 && !rd) begin
			if (first) begin
				ok = sh[7:1] == 7'h50 && !nack;
				rd = sh[0];
				first = 1'b0;
			end else
				ptr = int'(sh[1:0]);
			pull = ok;
		end else if (cnt == 8)
			ptr = ptr + 1;
		else if (rd && ok)
			pull = !rom[31 - 8 * (ptr % 4) - cnt];
	end
endmodule

// *** testbench/tb_sid_loader.sv ***
// self-checking bench for the subsystem_ident_doubleword loader
`timescale 1ns/1ps
module tb_sid_loader;
	import sid_pkg::*;
	logic clock = 1'b0;
	logic link_clock = 1'b0;
	logic reset = 1'b1;
	logic primary_bus_reset = 1'b0;
	logic global_reset = 1'b0;
	logic low_power_hold = 1'b0;
	logic strap = 1'b1;
	logic [2:0] cfg_func = 3'h0;
	logic [7:0] cfg_addr = 8'h00;
	logic cfg_wr = 1'b0;
	logic [31:0] cfg_wdata = 32'h0;
	logic [31:0] cfg_rdata, rom, idv;
	logic sda_oe, scl_oe, pull;
	logic nack = 1'b0;
	logic chk = 1'b0;
	logic chk_d = 1'b0;
	logic [39:0] q[$];
	logic [39:0] e;
	int num_errors = 0;
	int num_checks = 0;
	wire sda = !(sda_oe || pull);
	wire scl = !scl_oe;
	initial forever #20 clock = ~clock;
	initial begin
		#17;
		forever #62.5 link_clock = ~link_clock;
	end
	sid_loader #(.QTR_CYC(2)) sid_loader_inst (.clock(clock), .reset(reset),
		.link_clock(link_clock), .primary_bus_reset(primary_bus_reset),
		.global_reset(global_reset), .low_power_hold(low_power_hold),
		.power_switch_strobe_pin(strap), .cfg_func(cfg_func), .cfg_addr(cfg_addr),
		.cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.irq_mux_pin_6_i(sda), .irq_mux_pin_6_o(), .irq_mux_pin_6_oe(sda_oe),
		.irq_mux_pin_7_i(scl), .irq_mux_pin_7_o(), .irq_mux_pin_7_oe(scl_oe));
	sid_eeprom_model sid_eeprom_model_inst (.scl(scl), .sda(sda), .nack(nack), .rom(rom),
		.pull(pull));
	always @(posedge clock) chk_d <= chk;
	always @(negedge clock) begin
		if (chk_d) begin
			e = q.pop_front();
			num_checks++;
			if (cfg_rdata !== e[31:0]) begin
				num_errors++;
				$display("Error rdata %h: expected %h, seen %h", e[39:32], e[31:0], cfg_rdata);
			end
		end
	end
	task automatic rd(input logic [7:0] a, input logic [2:0] f, input logic [31:0] x);
		@(negedge clock);
		cfg_addr = a;
		cfg_func = f;
		chk = 1'b1;
		q.push_back({a, x});
		@(negedge clock);
		chk = 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clock);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(negedge clock);
		cfg_wr = 1'b0;
	endtask
	task automatic pulse(input logic g);
		@(negedge clock);
		global_reset = g;
		primary_bus_reset = !g;
		repeat (4) @(negedge clock);
		global_reset = 1'b0;
		primary_bus_reset = 1'b0;
	endtask
	task automatic busy(input logic x, input int lim);
		int i;
		for (i = 0; i < lim && cfg_rdata[2] !== x; i++)
			@(negedge clock);
		num_checks++;
		if (cfg_rdata[2] !== x) begin
			num_errors++;
			$display("Error busy: expected %b, seen %b", x, cfg_rdata[2]);
		end
	endtask
	task automatic load(input logic [31:0] st);
		@(negedge clock);
		cfg_addr = 8'h85;
		cfg_func = 3'h0;
		// the status decode is registered, so the first look waits one cycle
		@(negedge clock);
		busy(1'b1, 100);
		busy(1'b0, 5000);
		rd(8'h85, 3'h0, st);
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#1600000;
		num_errors++;
		$display("Error watchdog: expected end, seen hang");
		summarize();
	end
	initial begin
		void'($urandom(32'h083e));
		rom = $urandom;
		idv = $urandom;
		repeat (4) @(negedge clock);
		reset = 1'b0;
		rd(8'h85, 3'h0, 32'h0);
		rd(8'h80, 3'h1, SID_SYSCTL_RST);
		wr(8'h40, idv);
		rd(8'h40, 3'h0, 32'h0);
		wr(8'h80, 32'h0);
		wr(8'h40, idv);
		rd(8'h40, 3'h1, idv);
		wr(8'h80, 32'h20);
		wr(8'h40, ~idv);
		rd(8'h40, 3'h0, idv);
		rd(8'h40, 3'h2, 32'h0);
		rd(8'h44, 3'h0, 32'h0);
		$display("register test done");
		@(negedge clock);
		strap = 1'b0;
		reset = 1'b1;
		repeat (4) @(negedge clock);
		reset = 1'b0;
		load(32'h1);
		rd(8'h40, 3'h0, rom);
		$display("load test done");
		nack = 1'b1;
		pulse(1'b0);
		load(32'h3);
		rd(8'h40, 3'h0, 32'h0);
		$display("error test done");
		nack = 1'b0;
		wr(8'h80, 32'h0);
		low_power_hold = 1'b1;
		pulse(1'b0);
		pulse(1'b1);
		repeat (50) @(negedge clock);
		rd(8'h85, 3'h0, 32'h3);
		rd(8'h80, 3'h0, 32'h0);
		low_power_hold = 1'b0;
		rom = $urandom;
		pulse(1'b1);
		load(32'h1);
		rd(8'h40, 3'h0, rom);
		$display("hold test done");
		summarize();
	end
endmodule
